//--- src/pie_pkg.sv
// Constants and types for the peripheral interrupt enable register block
//
// Behaviour
// [R1] Software keeps reserved bits seven and six clear
// [R2] Bits five and four always read zero
// [R3] Bit three gates the serial port interrupt
// [R4] Bit two gates the capture/compare interrupt
// [R5] Bit one gates the period match interrupt
// [R6] Bit zero gates the timer overflow interrupt
// [R7] Nothing reaches core without global peripheral enable
// [R8] Implemented bits read/write, reset to zero
// [R9] Request is flag AND enable AND global enables
package pie_pkg;

  // ****************************************************************
  // Register map, byte addresses on the bus
  // ****************************************************************
  localparam logic [31:0] OFF_ENABLE = 32'h0000_0000;
  localparam logic [31:0] OFF_ICTL = 32'h0000_0004;
  localparam logic [31:0] OFF_FLAGS = 32'h0000_0008;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_SERIAL = 3;
  localparam int BIT_CAPCMP = 2;
  localparam int BIT_PMATCH = 1;
  localparam int BIT_TOVF = 0;
  localparam int BIT_PERIPH_EN = 6;
  localparam int BIT_GLOBAL_EN = 7;
  localparam int NUM_SRC = 4;

  // ****************************************************************
  // Masks and reset values
  // ****************************************************************
  localparam logic [7:0] ENABLE_RW_MASK = 8'hcf;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] ICTL_RW_MASK = 8'hc0;
  localparam logic [7:0] ICTL_RESET = 8'h00;
  localparam logic [3:0] FLAGS_RESET = 4'h0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ****************************************************************
  // Carriers between the bus front end and the register file
  // ****************************************************************
  typedef struct packed {
    logic en;
    logic [31:0] addr;
    logic [7:0] data;
  } pie_wr_type;

  typedef struct packed {
    logic en;
    logic [31:0] addr;
  } pie_rd_type;

endpackage

//--- src/pie_ahb_slave.sv
// AHB-Lite front end: captures the address phase, presents accesses
`timescale 1ns/1ps
module pie_ahb_slave
(
  input wire logic hclk, // Bus clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic hready, // Bus ready
  input wire logic [31:0] hwdata, // Write data
  output logic hreadyout, // Ready, from flop
  output logic hresp, // Response, from flop
  output pie_pkg::pie_wr_type wr, // Write in its data phase
  output pie_pkg::pie_rd_type rd // Read in its address phase
);

  logic wr_pend_q;
  logic [31:0] wr_addr_q;
  logic ready_q;
  logic resp_q;

  // Only whole-word NONSEQ or SEQ transfers are acted on
  wire logic take = hsel && htrans[1] && hready && (hsize == pie_pkg::HSIZE_WORD);

  // ****************************************************************
  // Address phase capture
  // ****************************************************************
  // Zero wait states, so out of reset the slave never stalls and is always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 32'h0000_0000;
      ready_q <= 1'b0;
      resp_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= take && hwrite;
      wr_addr_q <= haddr;
      ready_q <= 1'b1;
      resp_q <= 1'b0;
    end
  end

  assign hreadyout = ready_q;
  // Every transfer is OKAY; the response still leaves a flop like hreadyout
  assign hresp = resp_q;

  // Write data arrives one cycle after the address
  assign wr.en = wr_pend_q;
  assign wr.addr = wr_addr_q;
  assign wr.data = hwdata[7:0];

  // Reads are served from the address phase, data is registered upstream
  assign rd.en = take && !hwrite;
  assign rd.addr = haddr;

endmodule

//--- src/pie_regs.sv
// Peripheral interrupt enable register file with flags and core request
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
module pie_regs
(
  input wire logic hclk, // Bus clock, 40 MHz
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic hready, // Bus ready
  input wire logic [31:0] hwdata, // Write data
  output logic [31:0] hrdata, // Read data, from flop
  output logic hreadyout, // Ready, from flop
  output logic hresp, // Response, from flop
  input wire logic [3:0] periph_event, // Peripheral event pulses
  output logic [3:0] irq_req, // Per-source requests, from flop
  output logic irq // Interrupt to core, level
);

  pie_pkg::pie_wr_type wr;
  pie_pkg::pie_rd_type rd;
  logic [7:0] enable_q;
  logic [7:0] enable_d;
  logic [7:0] ictl_q;
  logic [7:0] ictl_d;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [3:0] irq_req_q;
  logic [3:0] irq_req_d;
  logic irq_q;
  logic irq_d;
  logic [31:0] hrdata_q;
  logic [31:0] hrdata_d;

  // ****************************************************************
  // Bus front end
  // ****************************************************************
  pie_ahb_slave u_bus
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .wr(wr),
    .rd(rd)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic wr_enable = wr.en && (wr.addr == pie_pkg::OFF_ENABLE);
  wire logic wr_ictl = wr.en && (wr.addr == pie_pkg::OFF_ICTL);
  wire logic wr_flags = wr.en && (wr.addr == pie_pkg::OFF_FLAGS);
  wire logic rd_enable = rd.addr == pie_pkg::OFF_ENABLE;
  wire logic rd_ictl = rd.addr == pie_pkg::OFF_ICTL;
  wire logic rd_flags = rd.addr == pie_pkg::OFF_FLAGS;

  // ****************************************************************
  // Next values of the registers
  // ****************************************************************
  // Bits five and four are masked off on every write, so they can never read back as one
  assign enable_d = wr_enable ? (wr.data & pie_pkg::ENABLE_RW_MASK) : enable_q; // [R2] [R8]
  assign ictl_d = wr_ictl ? (wr.data & pie_pkg::ICTL_RW_MASK) : ictl_q;

  // Write one to clear; an event in the same cycle wins over the clear
  wire logic [3:0] flag_clr = wr_flags ? wr.data[3:0] : 4'h0;
  assign flags_d = (flags_q & ~flag_clr) | periph_event;

  // Both global enables must be set before any source reaches the core
  wire logic periph_gate = ictl_q[pie_pkg::BIT_PERIPH_EN] && ictl_q[pie_pkg::BIT_GLOBAL_EN]; // [R7]

  // Per-source request: flag AND its own enable AND the global gate
  wire logic [3:0] masked = flags_q & enable_q[3:0];
  for (genvar i = 0; i < pie_pkg::NUM_SRC; i++)
  begin : g_req
    assign irq_req_d[i] = masked[i] && periph_gate; // [R3] [R4] [R5] [R6] [R9]
  end
  assign irq_d = (|masked) && periph_gate; // [R7] [R9]

  // Read mux uses next values so a read right after a write sees it
  assign hrdata_d = !rd.en ? 32'h0000_0000 :
                    rd_enable ? {24'h00_0000, enable_d} :
                    rd_ictl ? {24'h00_0000, ictl_d} :
                    rd_flags ? {28'h000_0000, flags_d} : 32'h0000_0000;

  // ****************************************************************
  // Register storage
  // ****************************************************************
  // All control state clears at reset, interrupts start blocked
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      enable_q <= pie_pkg::ENABLE_RESET; // [R8]
      ictl_q <= pie_pkg::ICTL_RESET;
      flags_q <= pie_pkg::FLAGS_RESET;
    end
    else
    begin
      enable_q <= enable_d;
      ictl_q <= ictl_d;
      flags_q <= flags_d;
    end
  end

  // Outputs are registered so the core sees no decode glitches
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_req_q <= 4'h0;
      irq_q <= 1'b0;
      hrdata_q <= 32'h0000_0000;
    end
    else
    begin
      irq_req_q <= irq_req_d;
      irq_q <= irq_d;
      hrdata_q <= hrdata_d;
    end
  end

  assign irq_req = irq_req_q;
  assign irq = irq_q;
  assign hrdata = hrdata_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Unimplemented bits never come back as one on a read of the register
  property p_unimpl_zero;
    rd.en && rd_enable |=> hrdata_q[5:4] == 2'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) // [R2]
    else $error("Unimplemented enable bits read nonzero");

  // Serial port request follows its flag and enable one cycle later
  property p_serial;
    irq_req_q[3] == $past(flags_q[3] && enable_q[3] && periph_gate);
  endproperty
  a_serial: assert property (p_serial) // [R3]
    else $error("Serial port request does not match flag and enable");

  // Capture/compare request blocked while its enable is clear
  property p_capcmp;
    !enable_q[2] ##1 !enable_q[2] |-> !irq_req_q[2];
  endproperty
  a_capcmp: assert property (p_capcmp) // [R4]
    else $error("Capture/compare request raised while disabled");

  // Period match request rises when flag, enable and gate are all set
  property p_pmatch;
    flags_q[1] && enable_q[1] && periph_gate |=> irq_req_q[1];
  endproperty
  a_pmatch: assert property (p_pmatch) // [R5]
    else $error("Period match request missing");

  // Overflow request follows flag and enable
  property p_tovf;
    irq_req_q[0] == $past(flags_q[0] && enable_q[0] && periph_gate);
  endproperty
  a_tovf: assert property (p_tovf) // [R6]
    else $error("Timer overflow request does not match flag and enable");

  // No request at all while the peripheral gate was closed
  property p_gate;
    !periph_gate |=> !irq && irq_req_q == 4'h0;
  endproperty
  a_gate: assert property (p_gate) // [R7]
    else $error("Interrupt reached core with peripheral gate closed");

  // A write to the enable register lands with its masked value
  property p_enable_write;
    wr_enable |=> enable_q == ($past(wr.data) & pie_pkg::ENABLE_RW_MASK);
  endproperty
  a_enable_write: assert property (p_enable_write) // [R8]
    else $error("Enable register did not take the written value");

  // Core interrupt is the OR of the per-source requests
  property p_combine;
    irq == (|irq_req_q);
  endproperty
  a_combine: assert property (p_combine) // [R9]
    else $error("Core interrupt disagrees with per-source requests");

  // An event in the clearing cycle keeps its flag
  property p_set_wins;
    periph_event[0] && wr_flags && wr.data[0] |=> flags_q[0];
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Flag lost when event met its clear");

  // Writing a one clears a flag when no event meets it
  property p_flag_clear;
    wr_flags && wr.data[1] && !periph_event[1] |=> !flags_q[1];
  endproperty
  a_flag_clear: assert property (p_flag_clear) // [R9]
    else $error("Flag not cleared by a written one");

  // The control register keeps only its two global bits
  property p_ictl_write;
    wr_ictl |=> ictl_q == ($past(wr.data) & pie_pkg::ICTL_RW_MASK);
  endproperty
  a_ictl_write: assert property (p_ictl_write) // [R7]
    else $error("Control register did not take the written value");

  // Idle or refused cycles leave zero on the read data
  property p_read_idle;
    !rd.en |=> hrdata_q == 32'h0000_0000;
  endproperty
  a_read_idle: assert property (p_read_idle) // [R2]
    else $error("Read data nonzero without a read");

endmodule

//--- tb/peripheral_irq_enable_reg_test.sv
// Self-checking bench for the peripheral interrupt enable register block
`timescale 1ns/1ps
module peripheral_irq_enable_reg_test;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = pie_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] periph_event = 4'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [3:0] irq_req;
  logic irq;
  logic hready;
  logic [31:0] rd;
  logic [3:0] src;
  int n_fail = 0;
  int checked = 0;

  // Single slave, so its ready is the bus ready
  assign hready = hreadyout;

  // 40 MHz clock
  always #12.5 hclk = ~hclk;

  pie_regs dut
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hready(hready),
    .hwdata(hwdata),
    .hrdata(hrdata),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .periph_event(periph_event),
    .irq_req(irq_req),
    .irq(irq)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Compare and count; a mismatch is reported at once
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t ns: saw %h, expected %h", $time, got, exp);
    end
  endtask

  // One AHB single word transfer; waits on ready, never on a fixed count
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // One-cycle event pulse, then time for flag and request to land
  task automatic pulse(input logic [3:0] ev);
    @(posedge hclk);
    periph_event <= ev;
    @(posedge hclk);
    periph_event <= 4'h0;
    repeat (3) @(posedge hclk);
  endtask

  // Request lines and the core interrupt move together, one edge late
  task automatic chk_irq(input logic [3:0] exp);
    repeat (2) @(posedge hclk);
    check({27'h0, irq, irq_req}, {27'h0, |exp, exp});
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ****************************************************************
  // Watchdog
  // ****************************************************************
  // The whole sequence needs well under 1500 cycles
  initial
  begin
    #(25 * 4000);
    n_fail++;
    print_verdict;
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    repeat (12) @(posedge hclk);
    check({31'h0, hreadyout}, 32'h0);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    check({31'h0, hreadyout}, 32'h1);
    chk_irq(4'h0);
    check({31'h0, hresp}, 32'h0);
    rchk(pie_pkg::OFF_ENABLE, 32'h0);
    rchk(pie_pkg::OFF_ICTL, 32'h0);
    rchk(pie_pkg::OFF_FLAGS, 32'h0);
    // Software keeps the reserved pair clear; the unimplemented pair is written as ones
    wr(pie_pkg::OFF_ENABLE, 32'hffff_ff3f);
    rchk(pie_pkg::OFF_ENABLE, 32'h0000_000f);
    // Byte-sized transfers are refused: the write is dropped and the read gives zero
    hsize <= 3'h0;
    wr(pie_pkg::OFF_ENABLE, 32'h0);
    rchk(pie_pkg::OFF_ENABLE, 32'h0);
    hsize <= pie_pkg::HSIZE_WORD;
    rchk(pie_pkg::OFF_ENABLE, 32'h0000_000f);
    wr(pie_pkg::OFF_ENABLE, 32'h0);
    rchk(pie_pkg::OFF_ENABLE, 32'h0);
    // An unmapped word swallows writes and reads zero
    wr(32'h0000_000c, 32'h0000_000f);
    rchk(32'h0000_000c, 32'h0);
    rchk(pie_pkg::OFF_ENABLE, 32'h0);
    wr(pie_pkg::OFF_ICTL, 32'h0000_00c0);
    rchk(pie_pkg::OFF_ICTL, 32'h0000_00c0);
    // Each source: blocked while its enable is clear, raised once set, then cleared
    for (int i = 0; i < 4; i++)
    begin
      src = 4'h1 << i;
      wr(pie_pkg::OFF_ENABLE, {28'h0, ~src});
      pulse(src);
      chk_irq(4'h0);
      wr(pie_pkg::OFF_ENABLE, {28'h0, src});
      chk_irq(src);
      rchk(pie_pkg::OFF_FLAGS, {28'h0, src});
      wr(pie_pkg::OFF_FLAGS, {28'h0, src});
      chk_irq(4'h0);
      rchk(pie_pkg::OFF_FLAGS, 32'h0);
    end
    // An event landing in the clearing cycle leaves its flag set
    fork
      wr(pie_pkg::OFF_FLAGS, 32'h0000_0001);
      begin
        repeat (2) @(posedge hclk);
        periph_event <= 4'h1;
        @(posedge hclk);
        periph_event <= 4'h0;
      end
    join
    rchk(pie_pkg::OFF_FLAGS, 32'h0000_0001);
    wr(pie_pkg::OFF_FLAGS, 32'h0000_0001);
    rchk(pie_pkg::OFF_FLAGS, 32'h0);
    // Global peripheral gate: no request without it, whatever the enables hold
    wr(pie_pkg::OFF_ENABLE, 32'h0000_000f);
    wr(pie_pkg::OFF_ICTL, 32'h0000_0080);
    pulse(4'hf);
    chk_irq(4'h0);
    wr(pie_pkg::OFF_ICTL, 32'h0000_0040);
    chk_irq(4'h0);
    wr(pie_pkg::OFF_ICTL, 32'h0000_00c0);
    chk_irq(4'hf);
    wr(pie_pkg::OFF_ICTL, 32'h0);
    chk_irq(4'h0);
    wr(pie_pkg::OFF_FLAGS, 32'h0000_000f);
    rchk(pie_pkg::OFF_FLAGS, 32'h0);
    // A reset in mid-run clears the enables again and stalls the bus meanwhile
    wr(pie_pkg::OFF_ENABLE, 32'h0000_000f);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    check({31'h0, hreadyout}, 32'h0);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    rchk(pie_pkg::OFF_ENABLE, 32'h0);
    print_verdict;
  end
endmodule
